// ### include/dpsr_pkg.sv
// Package for the dual preset shift register block
package dpsr_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0]  DPSR_CTRL_OFFSET   = 4'h0;
    localparam logic [3:0]  DPSR_STATUS_OFFSET = 4'h4;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int          DPSR_CTRL_CLEAR_BIT = 0;
    localparam logic [31:0] DPSR_CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] DPSR_READ_UNMAPPED  = 32'h0000_0000;
    localparam logic [3:0]  DPSR_STAGE_RESET    = 4'h0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int          DPSR_BUS_WAIT_CYCLES = 1;

endpackage

// ### hw/dpsr_shift_register.sv
// Four-stage dual preset shift register with Avalon-MM slave
//
// Function
// - Four stages ordered first to last shift data toward the last stage.
// - Clear with no active preset forces all stages low, regardless of the shift clock.
// - Presets act at once, regardless of the shift clock level, like clear.
// - Stages change through shifting only on a rising shift clock edge.
// - On a rising edge the first stage takes serial_in and each later stage its predecessor.
// - A stage preset is active when enable one and its first data, or enable two and its second data, are high.
// - With clear and the CTRL clear bit low, no shift edge and preset inactive, a stage holds its level.
// - Devices cascade by feeding last_stage_output to the next serial_in on a shared clock.
`timescale 1ns/100ps
`default_nettype none

module dpsr_shift_register
    import dpsr_pkg::*;
#(
    parameter int STAGES = 4
)
(
    input  wire logic                mclk,
    input  wire logic                reset_n,
    input  wire logic                shift_clk,
    input  wire logic                serial_in,
    input  wire logic                clear,
    input  wire logic                preset_enable_one,
    input  wire logic                preset_enable_two,
    input  wire logic [STAGES-1:0]   first_source_data,
    input  wire logic [STAGES-1:0]   second_source_data,
    output var  logic                last_stage_output,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output var  logic [31:0]         avs_readdata,
    output var  logic                avs_waitrequest
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int SW = 2 * STAGES + 5;

    logic [SW-1:0]     sync1_reg;
    logic [SW-1:0]     sync2_reg;
    logic              shift_clk_d_reg;
    logic              ser_s;
    logic              clr_s;
    logic              pe1_s;
    logic              pe2_s;
    logic              sclk_s;
    logic [STAGES-1:0] p1_s;
    logic [STAGES-1:0] p2_s;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {shift_clk, serial_in, clear, preset_enable_one,
                          preset_enable_two, first_source_data, second_source_data};
            sync2_reg <= sync1_reg;
        end
    end

    assign {sclk_s, ser_s, clr_s, pe1_s, pe2_s, p1_s, p2_s} = sync2_reg;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            shift_clk_d_reg <= 1'b0;
        else
            shift_clk_d_reg <= sclk_s;
    end

    // ----------------------------------------
    // Preset, clear and shift decode
    // ----------------------------------------
    logic              ctrl_clear_reg;
    logic              clear_eff;
    logic              shift_edge;
    logic [STAGES-1:0] preset_vec;
    logic [STAGES-1:0] stage_reg;
    logic [STAGES-1:0] stage_next;

    assign preset_vec = ({STAGES{pe1_s}} & p1_s) | ({STAGES{pe2_s}} & p2_s);
    assign clear_eff  = clr_s | ctrl_clear_reg;
    assign shift_edge = sclk_s & ~shift_clk_d_reg;

    always_comb
    begin
        stage_next = stage_reg;
        for (int i = 0; i < STAGES; i++)
        begin
            if (preset_vec[i])
                stage_next[i] = 1'b1;
            else if (clear_eff)
                stage_next[i] = 1'b0;
            else if (shift_edge)
                stage_next[i] = (i == 0) ? ser_s : stage_reg[i-1];
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            stage_reg <= DPSR_STAGE_RESET[STAGES-1:0];
        else
            stage_reg <= stage_next;
    end

    assign last_stage_output = stage_reg[STAGES-1];

    // ----------------------------------------
    // Avalon-MM slave, one wait cycle
    // ----------------------------------------
    logic       bus_req;
    logic       bus_take;
    logic [1:0] word_sel;

    assign bus_req  = avs_read | avs_write;
    assign bus_take = bus_req & ~avs_waitrequest;
    assign word_sel = avs_address[3:2];

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            avs_waitrequest <= 1'b1;
        else if (bus_req && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_clear_reg <= DPSR_CTRL_RESET[DPSR_CTRL_CLEAR_BIT];
        else if (bus_take && avs_write && word_sel == DPSR_CTRL_OFFSET[3:2]
                 && avs_byteenable[0])
            ctrl_clear_reg <= avs_writedata[DPSR_CTRL_CLEAR_BIT];
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            avs_readdata <= DPSR_READ_UNMAPPED;
        else if (avs_read && avs_waitrequest)
        begin
            if (word_sel == DPSR_CTRL_OFFSET[3:2])
                avs_readdata <= {31'h0000_0000, ctrl_clear_reg};
            else if (word_sel == DPSR_STATUS_OFFSET[3:2])
                avs_readdata <= {{(32-STAGES){1'b0}}, stage_reg};
            else
                avs_readdata <= DPSR_READ_UNMAPPED;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic clean;
    assign clean = ~clear_eff & (preset_vec == '0);

    AST_CLEAR_LOW: assert property (@(posedge mclk) disable iff (!reset_n)
        (clear_eff && preset_vec == '0) |=> (stage_reg == '0))
        else $error("clear did not empty the stages");

    AST_PRESET_NO_CLOCK: assert property (@(posedge mclk) disable iff (!reset_n)
        (!shift_edge && preset_vec != '0) |=>
        ((stage_reg & $past(preset_vec)) == $past(preset_vec)))
        else $error("preset did not act without shift edge");

    AST_CHANGE_ON_EDGE: assert property (@(posedge mclk) disable iff (!reset_n)
        ($past(clean) && stage_reg != $past(stage_reg)) |-> $past(shift_edge))
        else $error("stages changed without rising shift edge");

    AST_SHIFT_STEP: assert property (@(posedge mclk) disable iff (!reset_n)
        (shift_edge && clean) |=>
        (stage_reg == {$past(stage_reg[STAGES-2:0]), $past(ser_s)}))
        else $error("shift step wrong");

    AST_PRESET_SOURCE_ONE: assert property (@(posedge mclk) disable iff (!reset_n)
        (clear_eff && pe1_s && !pe2_s) |=> (stage_reg == $past(p1_s)))
        else $error("load from source one wrong");

    AST_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        (clean && !shift_edge) |=> (stage_reg == $past(stage_reg)))
        else $error("stages did not hold");

    AST_PRESET_HIGH: assert property (@(posedge mclk) disable iff (!reset_n)
        (!clear_eff && preset_vec != '0) |=>
        ((stage_reg & ~$past(preset_vec)) == ($past(stage_next) & ~$past(preset_vec)))
        && ((stage_reg & $past(preset_vec)) == $past(preset_vec)))
        else $error("preset without clear wrong");

    AST_LAST_OUT: assert property (@(posedge mclk) disable iff (!reset_n)
        (shift_edge && clean) |=> (last_stage_output == $past(stage_reg[STAGES-2])))
        else $error("serial output not from last stage");

    COV_SHIFT: cover property (@(posedge mclk) disable iff (!reset_n)
        shift_edge && clean && ser_s);
    COV_LOAD_TWO: cover property (@(posedge mclk) disable iff (!reset_n)
        clear_eff && pe2_s && p2_s != '0);
    COV_BUS_READ: cover property (@(posedge mclk) disable iff (!reset_n)
        bus_take && avs_read && word_sel == DPSR_STATUS_OFFSET[3:2]);

endmodule

`default_nettype wire

// ### bench/dpsr_far_model.sv
// Far-side driver model for the shift register pins
`timescale 1ns/100ps
`default_nettype none
module dpsr_far_model
(
    input  wire logic       mclk,
    output var  logic       shift_clk,
    output var  logic       serial_in,
    output var  logic       clear,
    output var  logic       preset_enable_one,
    output var  logic       preset_enable_two,
    output var  logic [3:0] first_source_data,
    output var  logic [3:0] second_source_data
);
    initial
    begin
        {shift_clk, serial_in, clear, preset_enable_one, preset_enable_two} = '0;
        {first_source_data, second_source_data} = '0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic load(input logic c, e1, e2, input logic [3:0] d1, d2);
        @(posedge mclk);
        clear <= c;
        preset_enable_one <= e1;
        preset_enable_two <= e2;
        first_source_data <= d1;
        second_source_data <= d2;
        idle(6);
    endtask
    task automatic preset_load(input logic e1, e2, input logic [3:0] d1, d2);
        load(1'b1, 1'b0, 1'b0, d1, d2);
        load(1'b0, e1, e2, d1, d2);
        load(1'b0, 1'b0, 1'b0, ~d1, ~d2);
    endtask
    task automatic shift_bit(input logic b);
        @(posedge mclk);
        serial_in <= b;
        idle(4);
        shift_clk <= 1'b1;
        idle(4);
        shift_clk <= 1'b0;
        serial_in <= ~b;
        idle(4);
    endtask
endmodule
`default_nettype wire

// ### bench/dual_preset_shift_register_tb_top.sv
// Self-checking bench for the dual preset shift register
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD %0t %h %h", $time, (a), (b)); end end
module dual_preset_shift_register_tb_top;
    import dpsr_pkg::*;
    logic mclk, reset_n, shift_clk, serial_in, clear, preset_enable_one;
    logic preset_enable_two, last_stage_output, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  first_source_data, second_source_data, avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, rnd;
    int          n_fail = 0, n_compared = 0, cyc = 0, seed = 88, m = 0;
    dpsr_shift_register u_dut (.mclk, .reset_n, .shift_clk, .serial_in, .clear,
        .preset_enable_one, .preset_enable_two, .first_source_data, .second_source_data,
        .last_stage_output, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest);
    dpsr_far_model u_far (.mclk, .shift_clk, .serial_in, .clear, .preset_enable_one,
        .preset_enable_two, .first_source_data, .second_source_data);
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge mclk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Compares all stages and the output pin with the model
    task automatic check_stages();
        u_far.idle(6);
        bus(1'b0, DPSR_STATUS_OFFSET, '0, 4'hf, rd);
        `CHK(rd[3:0], 4'(m))
        `CHK(last_stage_output, 1'(m >> 3))
    endtask
    initial
    begin
        {reset_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        check_stages();
        bus(1'b0, DPSR_CTRL_OFFSET, '0, 4'hf, rd);
        `CHK(rd, DPSR_CTRL_RESET)
        for (int i = 0; i < 8; i++)
        begin
            rnd = $random(seed);
            u_far.preset_load(i[0], i[1], rnd[3:0], rnd[7:4]);
            m = (i[0] ? rnd[3:0] : 0) | (i[1] ? rnd[7:4] : 0);
            check_stages();
        end
        rnd = $random(seed);
        u_far.load(1'b1, 1'b1, 1'b0, rnd[3:0], 4'h0);
        m = rnd[3:0];
        check_stages();
        u_far.load(1'b1, 1'b0, 1'b1, 4'h0, 4'h0);
        m = 0;
        check_stages();
        u_far.preset_load(1'b1, 1'b0, 4'hf, 4'h0);
        m = 15;
        for (int i = 0; i < 10; i++)
        begin
            rnd = $random(seed);
            u_far.shift_bit(rnd[0]);
            m = ((m << 1) | rnd[0]) & 15;
            check_stages();
            u_far.load(1'b0, 1'b0, 1'b0, rnd[7:4], rnd[11:8]);
            check_stages();
        end
        bus(1'b1, DPSR_CTRL_OFFSET, 32'h0000_0001, 4'h1, rd);
        m = 0;
        check_stages();
        bus(1'b1, DPSR_CTRL_OFFSET, 32'h0000_0000, 4'he, rd);
        bus(1'b0, DPSR_CTRL_OFFSET, '0, 4'hf, rd);
        `CHK(rd, 32'h0000_0001)
        bus(1'b1, DPSR_CTRL_OFFSET, 32'h0000_0000, 4'h1, rd);
        bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf, rd);
        bus(1'b0, 4'h8, '0, 4'hf, rd);
        `CHK(rd, DPSR_READ_UNMAPPED)
        bus(1'b0, DPSR_CTRL_OFFSET, '0, 4'hf, rd);
        `CHK(rd, 32'h0000_0000)
        report_and_stop();
    end
endmodule
`default_nettype wire
